// ### mss_pkg.sv
// Package with constants, command codes and trigger encodings for the matrix scan controller.
package mss_pkg;
  // Depth of the scan list, counted in list elements (single channel or range).
  localparam int LIST_DEPTH = 16;
  localparam int IDX_W = 4;
  // Card numbers are 01 to 99.
  localparam logic [6:0] CARD_MIN = 7'h01;
  localparam logic [6:0] CARD_MAX = 7'h63;
  // Largest row and column for the three matrix variants (16x16, 4x64, 8x32).
  localparam logic [5:0] ROW_MAX_V0 = 6'h0f;
  localparam logic [5:0] COL_MAX_V0 = 6'h0f;
  localparam logic [5:0] ROW_MAX_V1 = 6'h03;
  localparam logic [5:0] COL_MAX_V1 = 6'h3f;
  localparam logic [5:0] ROW_MAX_V2 = 6'h07;
  localparam logic [5:0] COL_MAX_V2 = 6'h1f;
  // Scan-complete position in the operation registers and its decimal weight.
  localparam int SCAN_DONE_BIT = 8;
  localparam logic [15:0] SCAN_DONE_WEIGHT = 16'h0100;
  // Status byte positions.
  localparam int STB_OPER_BIT = 7;
  localparam int STB_RQS_BIT = 6;
  localparam int STB_ESB_BIT = 5;
  localparam int STB_MAV_BIT = 4;
  localparam int STB_QUE_BIT = 3;
  // Reset values.
  localparam logic [15:0] ENABLE_RESET = 16'h0000;
  localparam logic [15:0] COND_VALUE = 16'h0000;
  // Trigger output pulse width, in nanoseconds, and its cycle count at 40 MHz.
  localparam int CLK_PERIOD_NS = 25;
  localparam int TRIG_PULSE_NS = 1000;
  localparam int TRIG_PULSE_CYC = (TRIG_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [7:0] TRIG_PULSE_LEN = 8'(TRIG_PULSE_CYC);
  // Trigger source codes carried in the command data.
  localparam logic [3:0] SRC_BUS = 4'h0;
  localparam logic [3:0] SRC_EXT = 4'h1;
  localparam logic [3:0] SRC_HOLD = 4'h2;
  localparam logic [3:0] SRC_IMM = 4'h3;
  localparam logic [3:0] SRC_TTL0 = 4'h8;
  // Commands from the host.
  typedef enum logic [3:0] {
    MSS_CMD_LIST_CLEAR, MSS_CMD_LIST_ADD, MSS_CMD_INIT, MSS_CMD_ABORT,
    MSS_CMD_TRIG, MSS_CMD_TRIG_SOURCE, MSS_CMD_OUT_STATE, MSS_CMD_RESET,
    MSS_CMD_COND_Q, MSS_CMD_EVENT_Q, MSS_CMD_ENABLE_W, MSS_CMD_ENABLE_Q,
    MSS_CMD_PRESET, MSS_CMD_STB_Q
  } mss_cmd_t;
  // Scan sequencer states.
  typedef enum logic {MSS_IDLE, MSS_RUN} mss_state_t;
endpackage : mss_pkg

// ### mss_scan_ctrl.sv
// Scan sequencer, trigger handling and operation status registers of the relay matrix.
// Summary of operation
// - Check every list entry; flag invalid ones.
// - Entry holds card 1-99, variant row, column.
// - List kept in given order, scanned so.
// - Entries are single channels or inclusive ranges.
// - Start closes first listed channel immediately.
// - Each selected trigger advances one channel.
// - Final trigger opens last channel, ends scan.
// - Reset command opens every channel.
// - Scan completion sets event bit 8.
// - Condition register never shows bit 8.
// - Sixteen-bit mask; enabled events raise summary bit 7.
// - Mask query returns last written value.
// - Event read returns 256 or 0, clears.
// - Abort leaves scan-complete bit cleared; a completion in the abort cycle still sets it.
// - Preset clears mask only.
// - Status byte bits 7,6,5,4,3 as defined.
// - Values are binary weights, bit n is 2^n.
// - Source: bus, external, hold, immediate, line 0-7.
// - Enabled output pulses low after each close.
// - Only one trigger output active at once.
module mss_scan_ctrl
  import mss_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic [1:0] variant_sel,
  input wire logic cmd_valid,
  input wire logic [3:0] cmd_code,
  input wire logic [15:0] cmd_data,
  input wire logic [6:0] ent_card,
  input wire logic [5:0] ent_row_first,
  input wire logic [5:0] ent_col_first,
  input wire logic [5:0] ent_row_last,
  input wire logic [5:0] ent_col_last,
  input wire logic bus_trg,
  input wire logic ext_trig_in,
  input wire logic [7:0] ttl_trig_in,
  input wire logic rqs_bit,
  input wire logic esb_bit,
  input wire logic mav_bit,
  input wire logic que_bit,
  output logic rsp_valid,
  output logic [15:0] rsp_data,
  output logic err_pulse,
  output logic chan_closed,
  output logic [6:0] chan_card,
  output logic [5:0] chan_row,
  output logic [5:0] chan_col,
  output logic scan_active,
  output logic [7:0] ttl_trig_out_n,
  output logic ext_trig_out_n,
  output logic [7:0] status_summary_byte
);
  // Decoded command strobes.
  mss_cmd_t cmd;
  logic c_clear, c_add, c_init, c_abort, c_trig, c_src, c_out, c_rst;
  logic c_evq, c_enw, c_preset;
  assign cmd = mss_cmd_t'(cmd_code);
  assign c_clear = cmd_valid && (cmd == MSS_CMD_LIST_CLEAR);
  assign c_add = cmd_valid && (cmd == MSS_CMD_LIST_ADD);
  assign c_init = cmd_valid && (cmd == MSS_CMD_INIT);
  assign c_abort = cmd_valid && (cmd == MSS_CMD_ABORT);
  assign c_trig = cmd_valid && (cmd == MSS_CMD_TRIG);
  assign c_src = cmd_valid && (cmd == MSS_CMD_TRIG_SOURCE);
  assign c_out = cmd_valid && (cmd == MSS_CMD_OUT_STATE);
  assign c_rst = cmd_valid && (cmd == MSS_CMD_RESET);
  assign c_evq = cmd_valid && (cmd == MSS_CMD_EVENT_Q);
  assign c_enw = cmd_valid && (cmd == MSS_CMD_ENABLE_W);
  assign c_preset = cmd_valid && (cmd == MSS_CMD_PRESET);

  // Row and column limits of the fitted matrix variant.
  logic [5:0] row_max, col_max;
  always_comb begin
    case (variant_sel)
      2'h1: begin
        row_max = ROW_MAX_V1;
        col_max = COL_MAX_V1;
      end
      2'h2: begin
        row_max = ROW_MAX_V2;
        col_max = COL_MAX_V2;
      end
      default: begin
        row_max = ROW_MAX_V0;
        col_max = COL_MAX_V0;
      end
    endcase
  end

  // Entry check: card in range, both ends inside the matrix, range not descending.
  logic ent_ok;
  assign ent_ok = (ent_card >= CARD_MIN) && (ent_card <= CARD_MAX)
                  && (ent_row_first <= row_max) && (ent_col_first <= col_max)
                  && (ent_row_last <= row_max) && (ent_col_last <= col_max)
                  && ({ent_row_first, ent_col_first} <= {ent_row_last, ent_col_last});

  // Scan list storage, one element per index, in the order given.
  logic [6:0] lst_card_reg [LIST_DEPTH];
  logic [11:0] lst_first_reg [LIST_DEPTH];
  logic [11:0] lst_last_reg [LIST_DEPTH];
  logic [IDX_W:0] lst_count_reg; // Number of stored elements.
  logic lst_bad_reg; // An invalid entry was offered since the last clear.
  mss_state_t state_reg;

  // List writes are refused while a scan runs or when the list is full.
  logic add_ok;
  assign add_ok = c_add && ent_ok && (state_reg == MSS_IDLE) && (lst_count_reg < (IDX_W + 1)'(LIST_DEPTH));

  // Storage, one generate entry per list element.
  for (genvar g = 0; g < LIST_DEPTH; g++) begin : g_list
    always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
        lst_card_reg[g] <= 7'h00;
        lst_first_reg[g] <= 12'h000;
        lst_last_reg[g] <= 12'h000;
      end else if (add_ok && (lst_count_reg[IDX_W-1:0] == IDX_W'(g))) begin
        // Appending keeps the host's order.
        lst_card_reg[g] <= ent_card;
        lst_first_reg[g] <= {ent_row_first, ent_col_first};
        lst_last_reg[g] <= {ent_row_last, ent_col_last};
      end
    end
  end

  // List bookkeeping: count and validity flag.
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      lst_count_reg <= '0;
      lst_bad_reg <= 1'b0;
      err_pulse <= 1'b0;
    end else begin
      err_pulse <= c_add && !add_ok;
      if (c_clear || c_rst) begin
        lst_count_reg <= '0;
        lst_bad_reg <= 1'b0;
      end else if (add_ok) begin
        lst_count_reg <= lst_count_reg + 1'b1;
      end else if (c_add && !ent_ok) begin
        // A bad entry spoils the whole list until it is cleared.
        lst_bad_reg <= 1'b1;
      end
    end
  end

  // Trigger source and output selection.
  logic [3:0] src_reg;
  logic out_on_reg;
  logic out_ttl_reg; // Set for a backplane line, clear for the external port.
  logic [2:0] out_line_reg;
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      src_reg <= SRC_IMM;
      out_on_reg <= 1'b0;
      out_ttl_reg <= 1'b0;
      out_line_reg <= 3'h0;
    end else if (c_rst) begin
      src_reg <= SRC_IMM;
      out_on_reg <= 1'b0;
    end else begin
      if (c_src) begin
        src_reg <= cmd_data[3:0];
      end
      if (c_out) begin
        // One selection register, so enabling a new output drops the old one.
        if (cmd_data[4]) begin
          out_on_reg <= 1'b1;
          out_ttl_reg <= cmd_data[3];
          out_line_reg <= cmd_data[2:0];
        end else if ((out_ttl_reg == cmd_data[3]) && (!cmd_data[3] || (out_line_reg == cmd_data[2:0]))) begin
          // Disabling only affects the output that is actually active.
          out_on_reg <= 1'b0;
        end
      end
    end
  end

  // Two-stage synchronisers for pin triggers, plus one history stage for edges.
  logic [8:0] trg_s1_reg, trg_s2_reg, trg_s3_reg;
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      trg_s1_reg <= 9'h1ff;
      trg_s2_reg <= 9'h1ff;
      trg_s3_reg <= 9'h1ff;
    end else begin
      trg_s1_reg <= {ext_trig_in, ttl_trig_in};
      trg_s2_reg <= trg_s1_reg;
      trg_s3_reg <= trg_s2_reg;
    end
  end
  logic [8:0] trg_fall;
  assign trg_fall = trg_s3_reg & ~trg_s2_reg;

  // Trigger from the selected source.
  logic trig_evt;
  always_comb begin
    case (src_reg)
      SRC_BUS: trig_evt = bus_trg || c_trig;
      SRC_EXT: trig_evt = trg_fall[8];
      SRC_HOLD: trig_evt = c_trig;
      SRC_IMM: trig_evt = 1'b1;
      default: trig_evt = src_reg[3] && trg_fall[src_reg[2:0]];
    endcase
  end

  // Scan sequencer.
  logic [IDX_W-1:0] idx_reg;
  logic close_evt; // A channel closed this cycle.
  logic done_evt; // The last channel opened this cycle.
  logic at_end;
  assign at_end = ({chan_row, chan_col} == lst_last_reg[idx_reg]);
  logic can_start;
  assign can_start = (lst_count_reg != '0) && !lst_bad_reg;
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_reg <= MSS_IDLE;
      idx_reg <= '0;
      chan_closed <= 1'b0;
      chan_card <= 7'h00;
      chan_row <= 6'h00;
      chan_col <= 6'h00;
      close_evt <= 1'b0;
      done_evt <= 1'b0;
    end else begin
      close_evt <= 1'b0;
      done_evt <= 1'b0;
      if (c_rst || c_abort) begin
        // Everything open, scan stopped.
        state_reg <= MSS_IDLE;
        chan_closed <= 1'b0;
      end else begin
        case (state_reg)
          MSS_IDLE: begin
            if (c_init && can_start) begin
              // First element closes at once.
              state_reg <= MSS_RUN;
              idx_reg <= '0;
              chan_closed <= 1'b1;
              chan_card <= lst_card_reg[0];
              {chan_row, chan_col} <= lst_first_reg[0];
              close_evt <= 1'b1;
            end
            // Triggers while idle leave the channels as they are.
          end
          MSS_RUN: begin
            if (trig_evt) begin
              if (!at_end) begin
                // Next channel inside a range, column first, then row.
                close_evt <= 1'b1;
                if (chan_col == col_max) begin
                  chan_col <= 6'h00;
                  chan_row <= chan_row + 1'b1;
                end else begin
                  chan_col <= chan_col + 1'b1;
                end
              end else if ({1'b0, idx_reg} != lst_count_reg - 1'b1) begin
                // Next list element.
                idx_reg <= idx_reg + 1'b1;
                chan_card <= lst_card_reg[idx_reg + 1'b1];
                {chan_row, chan_col} <= lst_first_reg[idx_reg + 1'b1];
                close_evt <= 1'b1;
              end else begin
                // List traversed: open the last channel and end.
                chan_closed <= 1'b0;
                state_reg <= MSS_IDLE;
                done_evt <= 1'b1;
              end
            end
          end
          default: state_reg <= MSS_IDLE;
        endcase
      end
    end
  end
  assign scan_active = (state_reg == MSS_RUN);

  // Trigger output pulse after each close, on the single enabled output.
  logic [7:0] pulse_cnt_reg;
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      pulse_cnt_reg <= 8'h00;
      ttl_trig_out_n <= 8'hff;
      ext_trig_out_n <= 1'b1;
    end else begin
      if (close_evt && out_on_reg) begin
        pulse_cnt_reg <= TRIG_PULSE_LEN;
      end else if (pulse_cnt_reg != 8'h00) begin
        pulse_cnt_reg <= pulse_cnt_reg - 1'b1;
      end
      // Low while the counter runs; only the selected output moves.
      ttl_trig_out_n <= ~(8'((pulse_cnt_reg != 8'h00) && out_on_reg && out_ttl_reg) << out_line_reg);
      ext_trig_out_n <= !((pulse_cnt_reg != 8'h00) && out_on_reg && !out_ttl_reg);
    end
  end

  // Operation event latch and enable mask.
  logic [15:0] event_reg;
  logic [15:0] enable_reg;
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      event_reg <= 16'h0000;
    end else if (done_evt) begin
      // A completion in the read cycle survives the clear.
      event_reg[SCAN_DONE_BIT] <= 1'b1;
    end else if (c_evq || c_abort) begin
      event_reg <= 16'h0000;
    end
  end
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      enable_reg <= ENABLE_RESET;
    end else if (c_preset) begin
      enable_reg <= ENABLE_RESET;
    end else if (c_enw) begin
      enable_reg <= cmd_data;
    end
  end

  // Status byte assembled from the summary and the outside status bits.
  logic [7:0] stb;
  always_comb begin
    stb = 8'h00;
    stb[STB_OPER_BIT] = |(event_reg & enable_reg);
    stb[STB_RQS_BIT] = rqs_bit;
    stb[STB_ESB_BIT] = esb_bit;
    stb[STB_MAV_BIT] = mav_bit;
    stb[STB_QUE_BIT] = que_bit;
  end
  assign status_summary_byte = stb;

  // Query answers, one cycle after the command, binary-weighted values.
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      rsp_valid <= 1'b0;
      rsp_data <= 16'h0000;
    end else begin
      rsp_valid <= 1'b0;
      if (cmd_valid) begin
        case (cmd)
          MSS_CMD_COND_Q: begin
            rsp_valid <= 1'b1;
            rsp_data <= COND_VALUE;
          end
          MSS_CMD_EVENT_Q: begin
            rsp_valid <= 1'b1;
            rsp_data <= event_reg[SCAN_DONE_BIT] ? SCAN_DONE_WEIGHT : 16'h0000;
          end
          MSS_CMD_ENABLE_Q: begin
            rsp_valid <= 1'b1;
            rsp_data <= enable_reg;
          end
          MSS_CMD_STB_Q: begin
            rsp_valid <= 1'b1;
            rsp_data <= {8'h00, stb};
          end
          default: rsp_valid <= 1'b0;
        endcase
      end
    end
  end

  // Checks.
  property p_idle_trig;
    @(posedge ref_clk) disable iff (!rst_n)
    (state_reg == MSS_IDLE) && !c_init |=> $stable({chan_closed, chan_card, chan_row, chan_col});
  endproperty
  a_idle_trig: assert property (p_idle_trig) else $error("Idle trigger moved channels.");
  property p_init_close;
    @(posedge ref_clk) disable iff (!rst_n)
    c_init && can_start && (state_reg == MSS_IDLE) && !c_abort && !c_rst |=> chan_closed && scan_active;
  endproperty
  a_init_close: assert property (p_init_close) else $error("Start did not close first channel.");
  property p_done_event;
    @(posedge ref_clk) disable iff (!rst_n)
    $fell(scan_active) && !$past(c_abort) && !$past(c_rst) |=> event_reg[SCAN_DONE_BIT];
  endproperty
  a_done_event: assert property (p_done_event) else $error("Completion did not set event.");
  property p_end_open;
    @(posedge ref_clk) disable iff (!rst_n)
    $fell(scan_active) |-> !chan_closed;
  endproperty
  a_end_open: assert property (p_end_open) else $error("Channel left closed at end.");
  property p_reset_open;
    @(posedge ref_clk) disable iff (!rst_n)
    c_rst |=> !chan_closed && !scan_active;
  endproperty
  a_reset_open: assert property (p_reset_open) else $error("Reset left a channel closed.");
  property p_event_read;
    @(posedge ref_clk) disable iff (!rst_n)
    c_evq && !done_evt |=> rsp_valid && (rsp_data == (($past(event_reg[SCAN_DONE_BIT])) ? 16'h0100 : 16'h0000))
      && !event_reg[SCAN_DONE_BIT];
  endproperty
  a_event_read: assert property (p_event_read) else $error("Event read wrong or not cleared.");
  property p_abort_clear;
    @(posedge ref_clk) disable iff (!rst_n)
    c_abort && !done_evt |=> !event_reg[SCAN_DONE_BIT];
  endproperty
  a_abort_clear: assert property (p_abort_clear) else $error("Abort left event set.");
  property p_summary;
    @(posedge ref_clk) disable iff (!rst_n)
    status_summary_byte[7] == (event_reg[8] && enable_reg[8]);
  endproperty
  a_summary: assert property (p_summary) else $error("Summary bit wrong.");
  property p_enable_read;
    @(posedge ref_clk) disable iff (!rst_n)
    c_enw ##1 (cmd_valid && (cmd == MSS_CMD_ENABLE_Q)) |=> rsp_data == $past(cmd_data, 2);
  endproperty
  a_enable_read: assert property (p_enable_read) else $error("Mask readback differs.");
  property p_one_output;
    @(posedge ref_clk) disable iff (!rst_n)
    $onehot0({~ttl_trig_out_n, ~ext_trig_out_n});
  endproperty
  a_one_output: assert property (p_one_output) else $error("Two trigger outputs active.");
  property p_bad_entry;
    @(posedge ref_clk) disable iff (!rst_n)
    c_add && !ent_ok |=> err_pulse ##1 (!scan_active || lst_bad_reg);
  endproperty
  a_bad_entry: assert property (p_bad_entry) else $error("Invalid entry not flagged.");
  c_scan_done: cover property (@(posedge ref_clk) disable iff (!rst_n) done_evt);
  c_range_step: cover property (@(posedge ref_clk) disable iff (!rst_n) scan_active && trig_evt && !at_end);
  c_pulse: cover property (@(posedge ref_clk) disable iff (!rst_n) !ext_trig_out_n || !(&ttl_trig_out_n));
endmodule : mss_scan_ctrl

// ### mss_host_model.sv
// Host-side model that drives the external and backplane trigger pins of the scan controller.
module mss_host_model
  import mss_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic fire,
  input wire logic [3:0] src,
  output logic ext_trig_in,
  output logic [7:0] ttl_trig_in
);
  timeunit 1ns;
  timeprecision 1ps;
  // Remaining low cycles of the trigger pulse in flight.
  logic [2:0] low_cnt_reg;
  // Each fire request starts a four-cycle low pulse.
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      low_cnt_reg <= 3'h0;
    end else if (fire) begin
      low_cnt_reg <= 3'h4;
    end else if (low_cnt_reg != 3'h0) begin
      low_cnt_reg <= low_cnt_reg - 3'h1;
    end
  end
  // Idle lines sit high as a pulled-up wire; only the line of the selected source falls.
  always_comb begin
    ext_trig_in = !((low_cnt_reg != 3'h0) && (src == SRC_EXT));
    ttl_trig_in = 8'hff;
    if ((low_cnt_reg != 3'h0) && src[3]) begin
      ttl_trig_in[src[2:0]] = 1'b0;
    end
  end
endmodule : mss_host_model

// ### mss_scan_ctrl_test.sv
// Self-checking testbench for the matrix scan controller.
module mss_scan_ctrl_test import mss_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  // Clock, reset and command port.
  logic ref_clk, rst_n, cmd_valid, bus_trg, fire;
  logic [1:0] variant_sel;
  logic [3:0] cmd_code, trig_src;
  logic [15:0] cmd_data, rsp_data;
  logic [6:0] ent_card, chan_card;
  logic [5:0] ent_row_first, ent_col_first, ent_row_last, ent_col_last, chan_row, chan_col;
  logic ext_trig_in, rqs_bit, esb_bit, mav_bit, que_bit, rsp_valid, err_pulse, chan_closed, scan_active;
  logic ext_trig_out_n;
  logic [7:0] ttl_trig_in, ttl_trig_out_n, status_summary_byte;
  // Scoreboard counters.
  int failures = 0;
  int cmp_count = 0;
  // Expected scan order: a single channel on card 2 first, then a wrapping range on card 1.
  logic [6:0] e_card[5] = '{7'h02, 7'h01, 7'h01, 7'h01, 7'h01};
  logic [5:0] e_row[5] = '{6'h03, 6'h00, 6'h00, 6'h01, 6'h01};
  logic [5:0] e_col[5] = '{6'h05, 6'h0e, 6'h0f, 6'h00, 6'h01};
  logic [3:0] srcs[5] = '{SRC_HOLD, SRC_BUS, SRC_EXT, SRC_TTL0 + 4'h5, SRC_IMM};

  mss_scan_ctrl dut_u (.ref_clk(ref_clk), .rst_n(rst_n), .variant_sel(variant_sel), .cmd_valid(cmd_valid),
    .cmd_code(cmd_code), .cmd_data(cmd_data), .ent_card(ent_card), .ent_row_first(ent_row_first),
    .ent_col_first(ent_col_first), .ent_row_last(ent_row_last), .ent_col_last(ent_col_last), .bus_trg(bus_trg),
    .ext_trig_in(ext_trig_in), .ttl_trig_in(ttl_trig_in), .rqs_bit(rqs_bit), .esb_bit(esb_bit), .mav_bit(mav_bit),
    .que_bit(que_bit), .rsp_valid(rsp_valid), .rsp_data(rsp_data), .err_pulse(err_pulse),
    .chan_closed(chan_closed), .chan_card(chan_card), .chan_row(chan_row), .chan_col(chan_col),
    .scan_active(scan_active), .ttl_trig_out_n(ttl_trig_out_n), .ext_trig_out_n(ext_trig_out_n),
    .status_summary_byte(status_summary_byte));
  mss_host_model host_u (.ref_clk(ref_clk), .rst_n(rst_n), .fire(fire), .src(trig_src),
    .ext_trig_in(ext_trig_in), .ttl_trig_in(ttl_trig_in));

  // Free-running 40 MHz clock.
  initial begin
    ref_clk = 1'b0;
    forever #12.5 ref_clk = ~ref_clk;
  end
  // Prints the counts and the verdict, then stops the run.
  task automatic test_done();
    $display("compares %0d mismatches %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : test_done
  // Compares one value and counts it.
  task automatic check(input logic [19:0] seen, input logic [19:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      failures++;
      $display("mismatch at %0t: seen 0x%h expected 0x%h", $time, seen, exp);
    end
  endtask : check
  // Issues one command for a single cycle; returns just after the edge that takes it.
  task automatic send(input mss_cmd_t c, input logic [15:0] d = 16'h0, input logic [6:0] cd = 7'h0,
      input logic [5:0] r1 = 6'h0, input logic [5:0] c1 = 6'h0, input logic [5:0] r2 = 6'h0,
      input logic [5:0] c2 = 6'h0);
    @(posedge ref_clk);
    cmd_valid <= 1'b1;
    cmd_code <= c;
    cmd_data <= d;
    {ent_card, ent_row_first, ent_col_first, ent_row_last, ent_col_last} <= {cd, r1, c1, r2, c2};
    @(posedge ref_clk);
    cmd_valid <= 1'b0;
    #1;
  endtask : send
  // Query whose answer is registered on the same edge that takes the command.
  task automatic query(input mss_cmd_t c, input logic [15:0] exp);
    send(c);
    check({19'h0, rsp_valid}, 20'h1);
    check({4'h0, rsp_data}, {4'h0, exp});
  endtask : query
  // Adds one list element and checks whether it was refused.
  task automatic add(input logic [6:0] cd, input logic [5:0] r1, c1, r2, c2, input logic err);
    send(MSS_CMD_LIST_ADD, 16'h0, cd, r1, c1, r2, c2);
    check({19'h0, err_pulse}, {19'h0, err});
  endtask : add
  // Bounded wait: 0 channel outputs, 1 trigger outputs, 2 channel-open-and-idle.
  task automatic wait_val(input int k, input logic [19:0] exp);
    logic [19:0] seen;
    for (int n = 0; n < 200; n++) begin
      seen = (k == 0) ? {chan_closed, chan_card, chan_row, chan_col} :
        (k == 1) ? {11'h0, ttl_trig_out_n, ext_trig_out_n} : {19'h0, chan_closed | scan_active};
      if (seen === exp) begin
        check(seen, exp);
        return;
      end
      @(posedge ref_clk);
      #1;
    end
    // The bound ran out: report through the one compare task and close the run.
    check(seen, exp);
    test_done();
  endtask : wait_val
  // Delivers one trigger from the given source; pins are left high long enough for the next edge.
  task automatic fire_trig(input logic [3:0] src);
    if (src == SRC_HOLD) begin
      send(MSS_CMD_TRIG);
    end else if (src != SRC_IMM) begin
      @(posedge ref_clk);
      bus_trg <= (src == SRC_BUS);
      fire <= (src != SRC_BUS);
      @(posedge ref_clk);
      bus_trg <= 1'b0;
      fire <= 1'b0;
      repeat (8) @(posedge ref_clk);
      #1;
    end
  endtask : fire_trig
  // Runs the whole list from one source; the hold run also exercises the trigger outputs.
  task automatic run_scan(input logic [3:0] src);
    trig_src <= src;
    send(MSS_CMD_TRIG_SOURCE, {12'h0, src});
    send(MSS_CMD_INIT);
    for (int i = 0; i < 5; i++) begin
      if (src != SRC_IMM) begin
        wait_val(0, {1'b1, e_card[i], e_row[i], e_col[i]});
      end
      if (src == SRC_HOLD && i == 0) begin
        wait_val(1, {11'h0, 8'hfb, 1'b1});
        send(MSS_CMD_OUT_STATE, 16'h0010);
        repeat (45) @(posedge ref_clk);
      end
      if (src == SRC_HOLD && i == 1) begin
        wait_val(1, {11'h0, 8'hff, 1'b0});
      end
      fire_trig(src);
    end
    wait_val(2, 20'h0);
  endtask : run_scan

  // Main sequence.
  initial begin
    {rst_n, cmd_valid, bus_trg, fire, variant_sel, cmd_code, cmd_data} = '0;
    {ent_card, ent_row_first, ent_col_first, ent_row_last, ent_col_last} = '0;
    trig_src = SRC_HOLD;
    {rqs_bit, esb_bit, mav_bit, que_bit} = 4'b1010;
    repeat (3) @(posedge ref_clk);
    rst_n <= 1'b1;
    repeat (4) @(posedge ref_clk);
    #1;
    check({12'h0, status_summary_byte}, 20'h00050);
    query(MSS_CMD_STB_Q, 16'h0050);
    query(MSS_CMD_ENABLE_Q, 16'h0000);
    query(MSS_CMD_COND_Q, 16'h0000);
    send(MSS_CMD_ENABLE_W, 16'hffff);
    query(MSS_CMD_ENABLE_Q, 16'hffff);
    send(MSS_CMD_ENABLE_W, 16'h0100);
    query(MSS_CMD_ENABLE_Q, 16'h0100);
    send(MSS_CMD_TRIG);
    fire_trig(SRC_BUS);
    check({18'h0, chan_closed, scan_active}, 20'h0);
    $display("test reset and mask done");
    send(MSS_CMD_LIST_CLEAR);
    add(7'h02, 6'h03, 6'h05, 6'h03, 6'h05, 1'b0);
    add(7'h01, 6'h00, 6'h0e, 6'h01, 6'h01, 1'b0);
    send(MSS_CMD_OUT_STATE, 16'h001a);
    send(MSS_CMD_TRIG_SOURCE, {12'h0, SRC_HOLD});
    send(MSS_CMD_INIT);
    check({chan_closed, chan_card, chan_row, chan_col}, {1'b1, e_card[0], e_row[0], e_col[0]});
    send(MSS_CMD_ABORT);
    wait_val(2, 20'h0);
    query(MSS_CMD_EVENT_Q, 16'h0000);
    for (int s = 0; s < 5; s++) begin
      run_scan(srcs[s]);
      repeat (2) @(posedge ref_clk);
      #1;
      check({19'h0, status_summary_byte[7]}, 20'h1);
      query(MSS_CMD_COND_Q, 16'h0000);
      query(MSS_CMD_EVENT_Q, 16'h0100);
      query(MSS_CMD_EVENT_Q, 16'h0000);
      check({19'h0, status_summary_byte[7]}, 20'h0);
    end
    $display("test scans done");
    run_scan(SRC_IMM);
    // Output switched off, then a scan aborted while a completion is still latched.
    trig_src <= SRC_HOLD;
    send(MSS_CMD_TRIG_SOURCE, {12'h0, SRC_HOLD});
    send(MSS_CMD_OUT_STATE, 16'h0000);
    send(MSS_CMD_INIT);
    wait_val(0, {1'b1, e_card[0], e_row[0], e_col[0]});
    repeat (3) @(posedge ref_clk);
    #1;
    check({11'h0, ttl_trig_out_n, ext_trig_out_n}, {11'h0, 8'hff, 1'b1});
    send(MSS_CMD_ABORT);
    wait_val(2, 20'h0);
    query(MSS_CMD_EVENT_Q, 16'h0000);
    run_scan(SRC_IMM);
    send(MSS_CMD_PRESET);
    query(MSS_CMD_ENABLE_Q, 16'h0000);
    check({12'h0, status_summary_byte}, 20'h00050);
    query(MSS_CMD_EVENT_Q, 16'h0100);
    trig_src <= SRC_HOLD;
    send(MSS_CMD_TRIG_SOURCE, {12'h0, SRC_HOLD});
    send(MSS_CMD_INIT);
    wait_val(0, {1'b1, e_card[0], e_row[0], e_col[0]});
    send(MSS_CMD_RESET);
    wait_val(2, 20'h0);
    $display("test preset and reset done");
    send(MSS_CMD_LIST_CLEAR);
    add(7'h00, 6'h00, 6'h00, 6'h00, 6'h00, 1'b1);
    add(7'h64, 6'h00, 6'h00, 6'h00, 6'h00, 1'b1);
    add(7'h01, 6'h10, 6'h00, 6'h10, 6'h00, 1'b1);
    send(MSS_CMD_LIST_CLEAR);
    @(posedge ref_clk);
    variant_sel <= 2'h1;
    add(7'h01, 6'h03, 6'h3f, 6'h03, 6'h3f, 1'b0);
    add(7'h01, 6'h04, 6'h00, 6'h04, 6'h00, 1'b1);
    @(posedge ref_clk);
    variant_sel <= 2'h2;
    add(7'h01, 6'h07, 6'h1f, 6'h07, 6'h1f, 1'b0);
    add(7'h01, 6'h07, 6'h20, 6'h07, 6'h20, 1'b1);
    send(MSS_CMD_INIT);
    repeat (3) @(posedge ref_clk);
    #1;
    check({19'h0, scan_active}, 20'h0);
    $display("test invalid list done");
    test_done();
  end
endmodule : mss_scan_ctrl_test
